// *** rtl/sp_uart_map.svh ***
// Register map, field positions and timing counts of the serial port
`ifndef SP_UART_MAP_SVH
`define SP_UART_MAP_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define SP_ADDR_CTRL 8'h98
`define SP_ADDR_DATA 8'h99

// ----------------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------------
`define SP_BIT_MODE_HI 7
`define SP_BIT_MODE_LO 6
`define SP_BIT_MPE 5
`define SP_BIT_REN 4
`define SP_BIT_TB8 3
`define SP_BIT_RB8 2
`define SP_BIT_TI 1
`define SP_BIT_RI 0
`define SP_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
// Last oversampling tick index of a bit (sixteen ticks per bit), and tick index of a bit's centre
`define SP_OVS_LAST 4'hF
`define SP_OVS_MID 4'h7
// Bits per shift-register transfer
`define SP_M0_BITS 4'h8
// Frame lengths including start and stop bits
`define SP_FRAME8 4'hA
`define SP_FRAME9 4'hB

`endif

// *** rtl/sp_uart_pkg.sv ***
// Types shared by the serial port design
package sp_uart_pkg;

  typedef enum logic [1:0] {
    SP_MODE_SHIFT = 2'b00,
    SP_MODE_8VAR = 2'b01,
    SP_MODE_9FIX = 2'b10,
    SP_MODE_9VAR = 2'b11
  } sp_mode_t;

  typedef enum logic [2:0] {
    SP_TX_IDLE = 3'b001,
    SP_TX_WAIT = 3'b010,
    SP_TX_SEND = 3'b100
  } sp_tx_state_t;

  typedef enum logic [2:0] {
    SP_RX_IDLE = 3'b001,
    SP_RX_START = 3'b010,
    SP_RX_BITS = 3'b100
  } sp_rx_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sp_sfr_req_t;

endpackage : sp_uart_pkg

// *** rtl/sp_sync.sv ***
// Two-flop synchroniser for a pin that idles high
`timescale 1ns/1ps
`default_nettype none

module sp_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : sp_sync

`default_nettype wire

// *** rtl/sp_uart.sv ***
// Serial port: four-mode transmitter and receiver with control registers
`timescale 1ns/1ps
`default_nettype none
`include "sp_uart_map.svh"

// Notes on behaviour
// - In the asynchronous modes, transmitter and receiver run independently and concurrently.
// - Finished byte held in buffer; next accepted frame overwrites it.
// - Data address write loads transmitter; read returns separate receive buffer.
// - Mode bits 7:6 select shift, 8-bit variable, 9-bit fixed, 9-bit variable.
// - Fixed 9-bit mode runs at clock/32, or clock/16 when doubled.
// - 9-bit modes with filter on: no receive flag if ninth bit 0.
// - 8-bit mode with filter on: no receive flag without valid stop.
// - Filter off: receive flag raised once a full byte with a valid stop bit arrives.
// - Reception starts only while receive-enable bit 4 is set; clearing it stops only asynchronous reception.
// - 9-bit modes send control bit 3 as ninth data bit.
// - Bit 2 latches received ninth bit, or stop bit in 8-bit mode.
// - Transmit flag set after 8th shift bit, or at stop start.
// - Receive flag set after 8th shift bit, or mid stop bit.
// - Shift mode: data on receive pin, clock on transmit pin, 8 bits.
// - Shift mode: data write starts transmission, LSB first.
// - Shift mode: receive starts with enable set and flag clear.
// - 8-bit frame: start 0, eight data LSB first, stop 1.
// - 9-bit frame: start 0, eight data, ninth bit, stop 1.
// - Frame kept only if flag clear and stop bit is 1.
// - Asynchronous reception begins on a falling edge of receive pin.
module sp_uart
  import sp_uart_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sp_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic baud_double,
  input wire logic tx_baud_tick,
  input wire logic rx_baud_tick,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  sp_mode_t mode_reg;
  logic multiproc_filter_enable_reg;
  logic rx_enable_reg;
  logic tx_ninth_bit_reg;
  logic rx_ninth_bit_reg;
  logic tx_done_flag_reg;
  logic rx_done_flag_reg;
  logic [7:0] rx_buf_reg;

  logic wr_ctrl;
  logic wr_data;
  logic nine_bit;
  logic [7:0] ctrl_value;

  assign wr_ctrl = sfr_req.wr && (sfr_req.addr == `SP_ADDR_CTRL);
  assign wr_data = sfr_req.wr && (sfr_req.addr == `SP_ADDR_DATA);
  assign nine_bit = mode_reg[1];
  assign ctrl_value = {mode_reg, multiproc_filter_enable_reg,
    rx_enable_reg, tx_ninth_bit_reg, rx_ninth_bit_reg,
    tx_done_flag_reg, rx_done_flag_reg};

  // Events raised by the engines
  logic ti_set;
  logic m0_rx_done;
  logic rx_commit;
  logic rx_ninth_value;
  logic [7:0] m0_rx_byte;
  logic [7:0] m0_sh_reg;
  logic [7:0] rx_byte;

  // --------------------------------------------------------------------
  // Receive pin synchroniser and tick sources
  // --------------------------------------------------------------------
  logic rxd_s;
  logic rxd_prev_reg;
  logic m2_div_reg;
  logic m2_tick;
  logic tx_tick;
  logic rx_tick;

  sp_sync u_rxd_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(rxd_in),
    .sync_out(rxd_s)
  );

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_prev_reg <= 1'b1;
      m2_div_reg <= 1'b0;
    end
    else
    begin
      rxd_prev_reg <= rxd_s;
      m2_div_reg <= ~m2_div_reg;
    end
  end

  // Fixed-rate tick
  // Sixteen ticks per bit: clock/2 gives clock/32, every cycle clock/16
  assign m2_tick = baud_double | m2_div_reg;
  assign tx_tick = (mode_reg == SP_MODE_9FIX) ? m2_tick : tx_baud_tick;
  assign rx_tick = (mode_reg == SP_MODE_9FIX) ? m2_tick : rx_baud_tick;

  // --------------------------------------------------------------------
  // Control/status register
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= SP_MODE_SHIFT;
      multiproc_filter_enable_reg <= 1'b0;
      rx_enable_reg <= 1'b0;
      tx_ninth_bit_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      mode_reg <= sp_mode_t'(sfr_req.wdata[`SP_BIT_MODE_HI:`SP_BIT_MODE_LO]);
      multiproc_filter_enable_reg <= sfr_req.wdata[`SP_BIT_MPE];
      rx_enable_reg <= sfr_req.wdata[`SP_BIT_REN];
      tx_ninth_bit_reg <= sfr_req.wdata[`SP_BIT_TB8];
    end
  end

  // Flags: a hardware set in the cycle of a software clear wins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_done_flag_reg <= 1'b0;
      rx_done_flag_reg <= 1'b0;
    end
    else
    begin
      if (ti_set)
        tx_done_flag_reg <= 1'b1;
      else if (wr_ctrl)
        tx_done_flag_reg <= sfr_req.wdata[`SP_BIT_TI];
      if (rx_commit || m0_rx_done)
        rx_done_flag_reg <= 1'b1;
      else if (wr_ctrl)
        rx_done_flag_reg <= sfr_req.wdata[`SP_BIT_RI];
    end
  end

  // Received ninth bit: hardware update wins over software write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_ninth_bit_reg <= 1'b0;
    else if (rx_commit)
      rx_ninth_bit_reg <= rx_ninth_value;
    else if (wr_ctrl)
      rx_ninth_bit_reg <= sfr_req.wdata[`SP_BIT_RB8];
  end

  // Receive holding buffer, overwritten by each accepted byte
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_buf_reg <= 8'h00;
    else if (m0_rx_done)
      rx_buf_reg <= m0_sh_reg;
    else if (rx_commit)
      rx_buf_reg <= rx_byte;
  end

  // Data address reads return the receive buffer, never the transmit data
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd)
    begin
      case (sfr_req.addr)
        `SP_ADDR_CTRL: sfr_rdata <= ctrl_value;
        `SP_ADDR_DATA: sfr_rdata <= rx_buf_reg;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Transmit engine, also runs shift-register transfers both ways
  // --------------------------------------------------------------------
  sp_tx_state_t tx_state_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_cnt_reg;
  logic [3:0] tx_div_reg;
  logic [3:0] tx_frame;
  logic m0_phase_reg;
  logic m0_rx_reg;
  logic m0_start_rx;

  assign tx_frame = nine_bit ? `SP_FRAME9 : `SP_FRAME8;
  // Shift-mode receive start
  // Done pulse covers the cycle before the flag shows
  assign m0_start_rx = (mode_reg == SP_MODE_SHIFT) && rx_enable_reg &&
    !rx_done_flag_reg && !m0_rx_done && !wr_data;
  assign m0_rx_byte = {rxd_s, m0_sh_reg[7:1]};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= SP_TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      tx_cnt_reg <= 4'h0;
      tx_div_reg <= 4'h0;
      m0_phase_reg <= 1'b0;
      m0_rx_reg <= 1'b0;
      m0_sh_reg <= 8'h00;
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      ti_set <= 1'b0;
      m0_rx_done <= 1'b0;
    end
    else
    begin
      ti_set <= 1'b0;
      m0_rx_done <= 1'b0;
      case (tx_state_reg)
        SP_TX_IDLE:
        begin
          txd_out <= 1'b1;
          rxd_oe <= 1'b0;
          tx_cnt_reg <= 4'h0;
          tx_div_reg <= 4'h0;
          m0_phase_reg <= 1'b0;
          if (wr_data)
          begin
            // Frame: start, data LSB first, ninth, stop
            tx_sh_reg <= {1'b1, nine_bit ? tx_ninth_bit_reg : 1'b1,
              sfr_req.wdata, 1'b0};
            m0_rx_reg <= 1'b0;
            tx_state_reg <= SP_TX_WAIT;
          end
          else if (m0_start_rx)
          begin
            m0_rx_reg <= 1'b1;
            tx_state_reg <= SP_TX_WAIT;
          end
        end
        SP_TX_WAIT:
        begin
          if (mode_reg == SP_MODE_SHIFT)
          begin
            // Drop start bit, data shifts out LSB first
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_state_reg <= SP_TX_SEND;
          end
          else if (tx_tick)
          begin
            // Start bit begins at the first valid tick
            txd_out <= tx_sh_reg[0];
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_cnt_reg <= 4'h1;
            tx_div_reg <= 4'h0;
            tx_state_reg <= SP_TX_SEND;
          end
        end
        SP_TX_SEND:
        begin
          if (mode_reg == SP_MODE_SHIFT)
          begin
            // Clock on transmit pin, data on receive pin
            m0_phase_reg <= ~m0_phase_reg;
            rxd_oe <= !m0_rx_reg;
            if (!m0_phase_reg)
            begin
              txd_out <= 1'b0;
              rxd_out <= tx_sh_reg[0];
            end
            else
            begin
              // Partner samples and data is captured on the rising edge
              txd_out <= 1'b1;
              tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
              m0_sh_reg <= m0_rx_byte;
              tx_cnt_reg <= tx_cnt_reg + 4'h1;
              if (tx_cnt_reg == `SP_M0_BITS - 4'h1)
              begin
                ti_set <= !m0_rx_reg;
                m0_rx_done <= m0_rx_reg;
                tx_state_reg <= SP_TX_IDLE;
              end
            end
          end
          else if (tx_tick)
          begin
            tx_div_reg <= tx_div_reg + 4'h1;
            if (tx_div_reg == `SP_OVS_LAST)
            begin
              if (tx_cnt_reg == tx_frame)
                tx_state_reg <= SP_TX_IDLE;
              else
              begin
                txd_out <= tx_sh_reg[0];
                tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
                // Flag at start of stop bit
                if (tx_cnt_reg == tx_frame - 4'h1)
                  ti_set <= 1'b1;
              end
            end
          end
        end
        default:
          tx_state_reg <= SP_TX_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Asynchronous receive engine
  // --------------------------------------------------------------------
  // Own state, counters and tick, free of the transmit engine
  sp_rx_state_t rx_state_reg;
  logic [3:0] rx_div_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_sh_reg;
  logic [3:0] rx_last;
  logic rx_sample;
  logic rx_accept;

  // Bits after start: eight data, optional ninth, then stop
  assign rx_last = nine_bit ? 4'h9 : 4'h8;
  assign rx_sample = (rx_state_reg == SP_RX_BITS) && rx_tick &&
    (rx_div_reg == `SP_OVS_LAST);
  assign rx_byte = rx_sh_reg[7:0];
  assign rx_ninth_value = nine_bit ? rx_sh_reg[8] : rxd_s;

  // Flag clear and stop high at the final shift
  // Filter on ninth bit; stop checked always
  assign rx_accept = !rx_done_flag_reg && rxd_s &&
    (!multiproc_filter_enable_reg || !nine_bit || rx_sh_reg[8]);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_reg <= SP_RX_IDLE;
      rx_div_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_commit <= 1'b0;
    end
    else
    begin
      rx_commit <= 1'b0;
      case (rx_state_reg)
        SP_RX_IDLE:
        begin
          rx_div_reg <= 4'h0;
          rx_bit_reg <= 4'h0;
          if (rx_enable_reg && (mode_reg != SP_MODE_SHIFT) &&
              rxd_prev_reg && !rxd_s)
            rx_state_reg <= SP_RX_START;
        end
        SP_RX_START:
        begin
          if (!rx_enable_reg || (mode_reg == SP_MODE_SHIFT))
            rx_state_reg <= SP_RX_IDLE;
          else if (rx_tick)
          begin
            rx_div_reg <= rx_div_reg + 4'h1;
            // Start bit must still be low at its centre
            if (rx_div_reg == `SP_OVS_MID)
            begin
              rx_div_reg <= 4'h0;
              rx_state_reg <= rxd_s ? SP_RX_IDLE : SP_RX_BITS;
            end
          end
        end
        SP_RX_BITS:
        begin
          if (!rx_enable_reg || (mode_reg == SP_MODE_SHIFT))
            rx_state_reg <= SP_RX_IDLE;
          else if (rx_tick)
          begin
            rx_div_reg <= rx_div_reg + 4'h1;
            if (rx_sample)
            begin
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == rx_last)
              begin
                // Mid stop bit decides the frame
                rx_commit <= rx_accept;
                rx_state_reg <= SP_RX_IDLE;
              end
              else
                rx_sh_reg[rx_bit_reg] <= rxd_s;
            end
          end
        end
        default:
          rx_state_reg <= SP_RX_IDLE;
      endcase
    end
  end

endmodule : sp_uart

`default_nettype wire

// *** testbench/sp_uart_sva.sv ***
// Assertion checker for the serial port top ports
`timescale 1ns/1ps
`default_nettype none

module sp_uart_sva
  import sp_uart_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sp_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic baud_double,
  input wire logic tx_baud_tick,
  input wire logic rx_baud_tick,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out
);
  // ----
  // Mode shadow
  // ----
  // Mirrors software writes; the port does not expose the mode
  logic [1:0] mode_reg;
  logic ren_reg;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= 2'h0;
      ren_reg <= 1'b0;
    end
    else if (sfr_req.wr && sfr_req.addr == 8'h98)
    begin
      mode_reg <= sfr_req.wdata[7:6];
      ren_reg <= sfr_req.wdata[4];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence ctrl_wr_s;
    sfr_req.wr && sfr_req.addr == 8'h98;
  endsequence
  sequence ctrl_rd_s;
    sfr_req.rd && sfr_req.addr == 8'h98;
  endsequence

  ctrl_readback_a: assert property (
    ctrl_wr_s ##1 !sfr_req.wr ##1 ctrl_rd_s |=>
    sfr_rdata[7:3] == $past(sfr_req.wdata[7:3], 3))
    else $error("control readback wrong");
  unmapped_read_a: assert property (
    sfr_req.rd && sfr_req.addr != 8'h98 && sfr_req.addr != 8'h99
    |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  shift_start_a: assert property (
    sfr_req.wr && sfr_req.addr == 8'h99 && mode_reg == 2'h0 &&
    !ren_reg && txd_out && $past(txd_out) && !rxd_oe &&
    !$past(sfr_req.wr && sfr_req.addr == 8'h99) &&
    !$past(sfr_req.wr && sfr_req.addr == 8'h99, 2)
    |-> ##3 rxd_oe && !txd_out
    && rxd_out == $past(sfr_req.wdata[0], 3))
    else $error("shift transmit start wrong");
  shift_len_a: assert property (
    $rose(rxd_oe) |-> ##15 rxd_oe)
    else $error("shift transfer too short");
  shift_clk_a: assert property (
    mode_reg == 2'h0 && $fell(txd_out) |=> txd_out)
    else $error("shift clock low too long");
  oe_mode_a: assert property (
    rxd_oe |-> mode_reg == 2'h0)
    else $error("pin driven outside shift mode");
  tx_tick_a: assert property (
    mode_reg[0] && $changed(txd_out) |->
    $past(tx_baud_tick) || $past(tx_baud_tick, 2))
    else $error("transmit bit without tick");
  fixed_rate_a: assert property (
    mode_reg == 2'h2 && !baud_double && $fell(txd_out)
    |-> ##31 !txd_out)
    else $error("fixed rate bit too short");
endmodule : sp_uart_sva

bind sp_uart sp_uart_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .baud_double(baud_double),
  .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
  .txd_out(txd_out));

`default_nettype wire

// *** testbench/sp_remote_node.sv ***
// Remote serial node driving frames onto the receive pin
`timescale 1ns/1ps
`default_nettype none

module sp_remote_node (
  input wire logic core_clk,
  output logic line_out
);
  initial line_out = 1'b1;

  // frame bit timing
  // A one-bit call with a short count models a glitch
  task automatic send(input logic [10:0] f, input int n,
                      input int cyc);
    @(negedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      line_out = f[i];
      repeat (cyc) @(negedge core_clk);
    end
    line_out = 1'b1;
  endtask : send
endmodule : sp_remote_node

`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sp_uart_pkg::*;
  logic core_clk, rst_n, baud_double, node_line, rxd_pin, acc, tx_tick;
  logic rxd_out, rxd_oe, txd_out;
  sp_sfr_req_t req;
  logic [7:0] rdata, d, e, c, last;
  logic [31:0] seed;
  logic [7:0] rd_q[$];
  logic [10:0] fr_q[$];
  int err_count, n_checks, bit_cyc, nbits;

  // Device owns the pin only while shifting out
  assign rxd_pin = rxd_oe ? rxd_out : node_line;

  sp_uart u_dut (.core_clk(core_clk), .rst_n(rst_n), .sfr_req(req),
    .sfr_rdata(rdata), .baud_double(baud_double), .tx_baud_tick(tx_tick),
    .rx_baud_tick(1'b1), .rxd_in(rxd_pin), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out));
  sp_remote_node u_node (.core_clk(core_clk), .line_out(node_line));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic stop_test();
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [10:0] ex,
                     input logic [10:0] sn);
    n_checks++;
    if (sn !== ex)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  function automatic logic [10:0] frm(input logic [7:0] v,
                                      input logic n9, input logic sb);
    if (nbits == 10)
      return {1'b0, sb, v, 1'b0};
    return {sb, n9, v, 1'b0};
  endfunction : frm

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge core_clk);
    req.wr = 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    rd_q.push_back(ex);
    @(negedge core_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge core_clk);
    req.rd = 1'b0;
  endtask : rd_chk

  task automatic tx(input logic [7:0] v, input logic n9);
    fr_q.push_back(nbits == 8 ? {3'h0, v} : frm(v, n9, 1'b1));
    wr_reg(8'h99, v);
  endtask : tx

  // ----
  // Output watchers
  // ----
  initial
  forever
  begin
    @(posedge core_clk);
    if (req.rd === 1'b1)
    begin
      @(negedge core_clk);
      chk("sfr_rdata", {3'h0, rd_q.pop_front()}, {3'h0, rdata});
    end
  end

  initial
  begin : frame_mon
    logic [10:0] f;
    forever
    begin
      @(negedge core_clk);
      f = '0;
      if (nbits == 8 && rxd_oe === 1'b1)
      begin
        for (int i = 0; i < 8; i++)
        begin
          while (txd_out !== 1'b0) @(negedge core_clk);
          while (txd_out !== 1'b1) @(negedge core_clk);
          f[i] = rxd_out;
        end
        chk("shift_frame", fr_q.pop_front(), f);
        while (rxd_oe === 1'b1) @(negedge core_clk);
      end
      else if (nbits > 8 && txd_out === 1'b0)
      begin
        repeat (bit_cyc / 2) @(negedge core_clk);
        for (int i = 0; i < nbits; i++)
        begin
          f[i] = txd_out;
          if (i < nbits - 1)
            repeat (bit_cyc) @(negedge core_clk);
        end
        chk("txd_frame", fr_q.pop_front(), f);
      end
    end
  end

  initial
  begin
    repeat (10000) @(posedge core_clk);
    err_count++;
    stop_test();
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    req = '0;
    baud_double = 1'b0;
    tx_tick = 1'b1;
    rst_n = 1'b0;
    seed = 32'h0000_000A;
    err_count = 0;
    n_checks = 0;
    bit_cyc = 16;
    nbits = 10;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    rd_chk(8'h98, 8'h00);
    rd_chk(8'h9A, 8'h00);
    wr_reg(8'h98, 8'h50);
    rd_chk(8'h98, 8'h50);
    d = rnd();
    e = rnd();
    tx_tick = 1'b0;
    fork
      tx(d, 1'b0);
      u_node.send(frm(e, 1'b0, 1'b1), 10, 16);
    join
    chk("txd_held", 11'h001, {10'h000, txd_out});
    tx_tick = 1'b1;
    repeat (200) @(negedge core_clk);
    rd_chk(8'h99, e);
    rd_chk(8'h98, 8'h57);
    u_node.send(frm(rnd(), 1'b0, 1'b1), 10, 16);
    rd_chk(8'h99, e);
    wr_reg(8'h98, 8'h70);
    u_node.send(frm(rnd(), 1'b0, 1'b0), 10, 16);
    rd_chk(8'h98, 8'h70);
    u_node.send(11'h000, 1, 4);
    repeat (200) @(negedge core_clk);
    rd_chk(8'h98, 8'h70);
    wr_reg(8'h98, 8'h40);
    u_node.send(frm(rnd(), 1'b0, 1'b1), 10, 16);
    rd_chk(8'h98, 8'h40);
    last = e;
    nbits = 11;
    for (int k = 0; k < 3; k++)
    begin
      c = (k < 2) ? 8'hF8 : 8'hD0;
      acc = !c[5] || (k == 1);
      wr_reg(8'h98, c);
      d = rnd();
      e = rnd();
      fork
        tx(d, c[3]);
        u_node.send(frm(e, k == 1, 1'b1), 11, 16);
      join
      repeat (20) @(negedge core_clk);
      if (acc)
        last = e;
      rd_chk(8'h98, c | 8'h02 | {5'h0, acc && k == 1, 1'b0, acc});
      rd_chk(8'h99, last);
    end
    for (int k = 0; k < 2; k++)
    begin
      baud_double = k[0];
      bit_cyc = k ? 16 : 32;
      wr_reg(8'h98, 8'h88);
      tx(rnd(), 1'b1);
      repeat (bit_cyc * 12) @(negedge core_clk);
      rd_chk(8'h98, 8'h8A);
    end
    nbits = 8;
    wr_reg(8'h98, 8'h00);
    tx(rnd(), 1'b0);
    wr_reg(8'h99, rnd());
    repeat (40) @(negedge core_clk);
    rd_chk(8'h98, 8'h02);
    d = rnd();
    fork
      wr_reg(8'h98, 8'h10);
      u_node.send({2'h3, d, 1'b1}, 9, 2);
    join
    repeat (40) @(negedge core_clk);
    rd_chk(8'h98, 8'h11);
    rd_chk(8'h99, d);
    repeat (20) @(negedge core_clk);
    stop_test();
  end
endmodule : tb

`default_nettype wire
